// [design/hpm_pin_output_source_mux.sv]
// register file and pin drive of hub pins 0 and 1
// Overview of operation
// - pins 0-7 input enable bits, reset one
// - source field 4:2 picks port or status
// - receive source: codes 000-011 forward remote pin
// - receive codes 100-111: lock, pass, frame, line
// - status code 000 drives register value
// - status 001/010: or/and of lock
// - status 011: and of enabled pass
// - status code 101 drives frame sync
// - transmit 000/001: and/or of selected pass
// - transmit 010/011: frame and line active
// - transmit 100 synced, 101 interrupt
// - bit 1 holds locally driven level
// - bit 0 driver enable, resets off
// - source and select reset to zero
// - pin 0 at 0x10, pin 1 at 0x11
// - status register reads all eight pins
// - receive port enables gate combined lock and pass; transmit pass uses its rx_select ports
`include "hpm_regs.svh"

module hpm_pin_output_source_mux #(
    parameter int RX_PORTS = 4,
    parameter int PIN_COUNT = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,

    // register access
    input wire hpm_pkg::hpm_reg_req_t reg_req,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,

    // general purpose pins
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [PIN_COUNT-1:0] pin_input_enable,

    // receive port enables seen by the receivers
    output logic [RX_PORTS-1:0] receive_port_enable,

    // signal sources
    input wire hpm_pkg::hpm_rx_t rx,
    input wire hpm_pkg::hpm_tx_t [1:0] tx,
    input wire logic frame_sync_pulse
);
    import hpm_pkg::*;

    // the encodings of the select fields are fixed to four ports and eight pins
    if (RX_PORTS != 4) begin : g_rx_check
        $error("hpm_pin_output_source_mux: RX_PORTS must be 4");
    end
    if (PIN_COUNT != 8) begin : g_pin_check
        $error("hpm_pin_output_source_mux: PIN_COUNT must be 8");
    end

    // whole state of the register file
    typedef struct packed {
        hpm_pin_ctl_t [1:0] pin_ctl;
        logic [7:0] input_en;
        logic [3:0] rx_en;
        logic [7:0] rd_data;
        logic rd_valid;
    } hpm_state_t;

    hpm_state_t state_r;
    hpm_state_t state_nxt;

    // decoded strobes
    logic wr_pin0;
    logic wr_pin1;
    logic wr_input_en;
    logic wr_rx_en;
    logic [7:0] pin_level;
    hpm_pin_ctl_t wr_ctl;
    hpm_dev_t dev;
    logic [1:0] pin_level_sel;

    assign wr_pin0 = reg_req.wr_en && (reg_req.addr == `HPM_ADDR_PIN0_CTL);
    assign wr_pin1 = reg_req.wr_en && (reg_req.addr == `HPM_ADDR_PIN1_CTL);
    assign wr_input_en = reg_req.wr_en && (reg_req.addr == `HPM_ADDR_INPUT_EN);
    assign wr_rx_en = reg_req.wr_en && (reg_req.addr == `HPM_ADDR_RX_PORT_EN);

    // split the write data into the control fields
    always_comb begin
        wr_ctl.sel = reg_req.wdata[`HPM_SEL_MSB:`HPM_SEL_LSB];
        wr_ctl.src = hpm_src_t'(reg_req.wdata[`HPM_SRC_MSB:`HPM_SRC_LSB]);
        wr_ctl.drive_value = reg_req.wdata[`HPM_VAL_BIT];
        wr_ctl.driver_enable = reg_req.wdata[`HPM_OEN_BIT];
    end

    // live level of all pins
    // a disabled input buffer reads low, as the pad would
    assign pin_level = pin_in & state_r.input_en;

    // next state: writes land at the edge, reads answer one cycle later
    always_comb begin
        state_nxt = state_r;
        state_nxt.rd_valid = reg_req.rd_en;
        if (wr_pin0) begin
            state_nxt.pin_ctl[0] = wr_ctl;
        end
        if (wr_pin1) begin
            state_nxt.pin_ctl[1] = wr_ctl;
        end
        if (wr_input_en) begin
            state_nxt.input_en = reg_req.wdata;
        end
        if (wr_rx_en) begin
            state_nxt.rx_en = reg_req.wdata[3:0];
        end
        if (reg_req.rd_en) begin
            unique case (reg_req.addr)
                `HPM_ADDR_PIN0_CTL: state_nxt.rd_data = state_r.pin_ctl[0];
                `HPM_ADDR_PIN1_CTL: state_nxt.rd_data = state_r.pin_ctl[1];
                `HPM_ADDR_INPUT_EN: state_nxt.rd_data = state_r.input_en;
                `HPM_ADDR_RX_PORT_EN: state_nxt.rd_data = {4'h0, state_r.rx_en};
                `HPM_ADDR_PIN_LEVEL: state_nxt.rd_data = pin_level;
                // unmapped offsets read a fixed value, writes to them vanish
                default: state_nxt.rd_data = `HPM_UNMAPPED_RD;
            endcase
        end
    end

    // register the state; reset values match the register defaults
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r.pin_ctl[0] <= hpm_pin_ctl_t'(`HPM_PIN_CTL_RST);
            state_r.pin_ctl[1] <= hpm_pin_ctl_t'(`HPM_PIN_CTL_RST);
            state_r.input_en <= `HPM_INPUT_EN_RST;
            state_r.rx_en <= `HPM_RX_PORT_EN_RST;
            state_r.rd_data <= 8'h00;
            state_r.rd_valid <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // combined lock and pass indications over the enabled or selected ports
    hpm_status_combine u_combine (
        .rx(rx),
        .tx(tx),
        .rx_enable(state_r.rx_en),
        .dev(dev)
    );

    // one selector per driven pin
    for (genvar p = 0; p < 2; p++) begin : g_pin
        hpm_pin_select u_select (
            .clk(clk),
            .rst_n(rst_n),
            .ctl(state_r.pin_ctl[p]),
            .rx(rx),
            .tx(tx),
            .dev(dev),
            .frame_sync_pulse(frame_sync_pulse),
            .level(pin_level_sel[p])
        );
    end

    // driver enable to pad
    // the level is registered inside the selector, so the pad sees no glitch
    assign pin_out = pin_level_sel;
    assign pin_oe[0] = state_r.pin_ctl[0].driver_enable;
    assign pin_oe[1] = state_r.pin_ctl[1].driver_enable;

    // enables handed to the pads and receivers
    assign pin_input_enable = state_r.input_en;
    assign receive_port_enable = state_r.rx_en;

    // register read port
    assign reg_rd_data = state_r.rd_data;
    assign reg_rd_valid = state_r.rd_valid;
endmodule

// [design/hpm_pin_select.sv]
// signal selection and output register of one hub pin
module hpm_pin_select (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin control and sources
    input wire hpm_pkg::hpm_pin_ctl_t ctl,
    input wire hpm_pkg::hpm_rx_t rx,
    input wire hpm_pkg::hpm_tx_t [1:0] tx,
    input wire hpm_pkg::hpm_dev_t dev,
    input wire logic frame_sync_pulse,
    // registered pin level
    output logic level
);
    import hpm_pkg::*;

    typedef struct packed {
        logic level;
    } hpm_sel_state_t;

    hpm_sel_state_t state_r;
    hpm_sel_state_t state_nxt;
    logic [1:0] rx_idx;
    logic tx_idx;

    assign rx_idx = ctl.src[1:0];
    assign tx_idx = ctl.src[0];

    // pick the signal named by source and select
    always_comb begin
        state_nxt = state_r;
        state_nxt.level = 1'b0;
        unique case (ctl.src)
            HPM_SRC_RX0, HPM_SRC_RX1, HPM_SRC_RX2, HPM_SRC_RX3: begin
                unique case (ctl.sel)
                    3'b100: state_nxt.level = rx.lock[rx_idx];
                    3'b101: state_nxt.level = rx.pass[rx_idx];
                    3'b110: state_nxt.level = rx.frame_valid[rx_idx];
                    3'b111: state_nxt.level = rx.line_valid[rx_idx];
                    default: state_nxt.level = rx.remote_pins[rx_idx][ctl.sel[1:0]];
                endcase
            end
            HPM_SRC_DEV: begin
                unique case (ctl.sel)
                    3'b000: state_nxt.level = ctl.drive_value;
                    3'b001: state_nxt.level = dev.lock_or;
                    3'b010: state_nxt.level = dev.lock_and;
                    3'b011: state_nxt.level = dev.pass_and;
                    3'b101: state_nxt.level = frame_sync_pulse;
                    default: state_nxt.level = 1'b0;
                endcase
            end
            HPM_SRC_TX0, HPM_SRC_TX1: begin
                unique case (ctl.sel)
                    3'b000: state_nxt.level = dev.tx_pass_and[tx_idx];
                    3'b001: state_nxt.level = dev.tx_pass_or[tx_idx];
                    3'b010: state_nxt.level = tx[tx_idx].frame_active;
                    3'b011: state_nxt.level = tx[tx_idx].line_active;
                    3'b100: state_nxt.level = tx[tx_idx].synced;
                    3'b101: state_nxt.level = tx[tx_idx].irq;
                    default: state_nxt.level = 1'b0;
                endcase
            end
            default: state_nxt.level = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level = state_r.level;
endmodule

// [design/hpm_pkg.sv]
// types shared by the hub pin output block
package hpm_pkg;

    // output source codes
    typedef enum logic [2:0] {
        HPM_SRC_RX0 = 3'b000,
        HPM_SRC_RX1 = 3'b001,
        HPM_SRC_RX2 = 3'b010,
        HPM_SRC_RX3 = 3'b011,
        HPM_SRC_DEV = 3'b100,
        HPM_SRC_RSV = 3'b101,
        HPM_SRC_TX0 = 3'b110,
        HPM_SRC_TX1 = 3'b111
    } hpm_src_t;

    // one pin control register, laid out as in the register
    typedef struct packed {
        logic [2:0] sel;
        hpm_src_t src;
        logic drive_value;
        logic driver_enable;
    } hpm_pin_ctl_t;

    // signals coming from the four receive ports
    typedef struct packed {
        logic [3:0][3:0] remote_pins;
        logic [3:0] lock;
        logic [3:0] pass;
        logic [3:0] frame_valid;
        logic [3:0] line_valid;
    } hpm_rx_t;

    // signals coming from one camera transmit port
    typedef struct packed {
        logic [3:0] rx_select;
        logic frame_active;
        logic line_active;
        logic synced;
        logic irq;
    } hpm_tx_t;

    // combined status indications
    typedef struct packed {
        logic lock_or;
        logic lock_and;
        logic pass_and;
        logic [1:0] tx_pass_and;
        logic [1:0] tx_pass_or;
    } hpm_dev_t;

    // register access request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpm_reg_req_t;

endpackage

// [design/hpm_regs.svh]
// register offsets, field positions and reset values of the hub pin output block
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH

// register offsets on the serial control bus
`define HPM_ADDR_RX_PORT_EN 8'h0c
`define HPM_ADDR_PIN_LEVEL 8'h0e
`define HPM_ADDR_INPUT_EN 8'h0f
`define HPM_ADDR_PIN0_CTL 8'h10
`define HPM_ADDR_PIN1_CTL 8'h11

// pin control field positions
`define HPM_SEL_MSB 7
`define HPM_SEL_LSB 5
`define HPM_SRC_MSB 4
`define HPM_SRC_LSB 2
`define HPM_VAL_BIT 1
`define HPM_OEN_BIT 0

// input enable bits of pins 0 to 2
`define HPM_IEN0_BIT 0
`define HPM_IEN1_BIT 1
`define HPM_IEN2_BIT 2

// reset values
`define HPM_PIN_CTL_RST 8'h00
`define HPM_INPUT_EN_RST 8'hff
`define HPM_RX_PORT_EN_RST 4'hf
`define HPM_UNMAPPED_RD 8'h00

// latency of the pin path, in clock cycles
`define HPM_PIN_PIPE 1

`endif

// [design/hpm_status_combine.sv]
// combines lock and pass indications of the enabled or selected receive ports
module hpm_status_combine (
    // receive and transmit side
    input wire hpm_pkg::hpm_rx_t rx,
    input wire hpm_pkg::hpm_tx_t [1:0] tx,
    input wire logic [3:0] rx_enable,
    // combined result
    output hpm_pkg::hpm_dev_t dev
);
    import hpm_pkg::*;

    // an empty set of ports gives low, never a false good indication
    always_comb begin
        dev.lock_or = |(rx.lock & rx_enable);
        dev.lock_and = (|rx_enable) & (&(rx.lock | ~rx_enable));
        dev.pass_and = (|rx_enable) & (&(rx.pass | ~rx_enable));
        for (int t = 0; t < 2; t++) begin
            dev.tx_pass_and[t] = (|tx[t].rx_select) & (&(rx.pass | ~tx[t].rx_select));
            dev.tx_pass_or[t] = |(rx.pass & tx[t].rx_select);
        end
    end
endmodule

// [verification/hpm_assertions.sv]
// concurrent checks on the ports of the hub pin output block
module hpm_chk #(
    parameter int RX_PORTS = 4,
    parameter int PIN_COUNT = 8
) (
    // clock, reset and register access
    input wire logic clk,
    input wire logic rst_n,
    input wire hpm_pkg::hpm_reg_req_t reg_req,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    // pins and sources
    input wire logic [PIN_COUNT-1:0] pin_in,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [PIN_COUNT-1:0] pin_input_enable,
    input wire logic [RX_PORTS-1:0] receive_port_enable,
    input wire hpm_pkg::hpm_rx_t rx
);
    timeunit 1ns;
    timeprecision 1ps;
    import hpm_pkg::*;

    logic [7:0] ctl0_r;

    // shadow of the pin 0 control, so pin checks need no hierarchy
    always_ff @(posedge clk) begin
        if (!rst_n)
            ctl0_r <= 8'h00;
        else if (reg_req.wr_en && reg_req.addr == 8'h10)
            ctl0_r <= reg_req.wdata;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_oe0;
        reg_req.wr_en && reg_req.addr == 8'h10 |=> pin_oe[0] == $past(reg_req.wdata[0]);
    endproperty
    a_oe0: assert property (p_oe0) else $error("pin 0 enable wrong");
    property p_oe1;
        reg_req.wr_en && reg_req.addr == 8'h11 |=> pin_oe[1] == $past(reg_req.wdata[0]);
    endproperty
    a_oe1: assert property (p_oe1) else $error("pin 1 enable wrong");
    property p_sts;
        reg_req.rd_en && reg_req.addr == 8'h0e
            |=> reg_rd_valid && reg_rd_data == $past(pin_in & pin_input_enable);
    endproperty
    a_sts: assert property (p_sts) else $error("level read wrong");
    property p_ien;
        reg_req.wr_en && reg_req.addr == 8'h0f |=> pin_input_enable == $past(reg_req.wdata);
    endproperty
    a_ien: assert property (p_ien) else $error("input enables wrong");
    property p_rxen;
        reg_req.wr_en && reg_req.addr == 8'h0c
            |=> receive_port_enable == $past(reg_req.wdata[3:0]);
    endproperty
    a_rxen: assert property (p_rxen) else $error("port enables wrong");
    property p_val;
        ctl0_r[7:2] == 6'b000100 && $stable(ctl0_r) |-> pin_out[0] == ctl0_r[1];
    endproperty
    a_val: assert property (p_val) else $error("value bit not driven");
    property p_rsv;
        ctl0_r[4:2] == 3'b101 && $stable(ctl0_r) |-> !pin_out[0];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved source not low");
    property p_lock;
        ctl0_r[7:2] == 6'b100010 && $stable(ctl0_r) |-> pin_out[0] == $past(rx.lock[2]);
    endproperty
    a_lock: assert property (p_lock) else $error("lock not forwarded");
endmodule

bind hpm_pin_output_source_mux hpm_chk #(.RX_PORTS(RX_PORTS), .PIN_COUNT(PIN_COUNT)) chk_u (
    .clk, .rst_n, .reg_req, .reg_rd_data, .reg_rd_valid, .pin_in, .pin_out, .pin_oe,
    .pin_input_enable, .receive_port_enable, .rx);

// [verification/hpm_board.sv]
// board model that ties the hub pins to board levels
module hpm_board (
    // board side and pin drive
    input wire logic [7:0] board_lvl,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driven pin reads its own level, otherwise the board wins
    assign pin_in = {board_lvl[7:2], pin_oe[1] ? pin_out[1] : board_lvl[1],
                     pin_oe[0] ? pin_out[0] : board_lvl[0]};
endmodule

// [verification/hpm_pin_output_source_mux_tb.sv]
// self-checking bench of the hub pin output block
module hpm_pin_output_source_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hpm_pkg::*;

    logic clk, rst_n, rd_valid, fs;
    logic [7:0] rd_data, board_lvl, pin_in, ien_o;
    logic [1:0] pin_out, pin_oe;
    logic [3:0] rx_en, rxen_o;
    hpm_reg_req_t req;
    hpm_rx_t rx;
    hpm_tx_t [1:0] tx;
    int err_total, checked;
    // source patterns: rx, tx pair, frame sync, port enables
    logic [52:0] pat [3] = '{{32'hffff_ffff, 16'hffff, 1'b1, 4'hf},
        {32'h5a3c_7a5c, 16'h3ac5, 1'b0, 4'h7}, {32'ha5c3_85a3, 16'h5ca3, 1'b1, 4'hf}};

    hpm_pin_output_source_mux dut_u (.clk, .rst_n, .reg_req(req), .reg_rd_data(rd_data),
        .reg_rd_valid(rd_valid), .pin_in, .pin_out, .pin_oe, .pin_input_enable(ien_o),
        .receive_port_enable(rxen_o), .rx, .tx, .frame_sync_pulse(fs));
    hpm_board board_u (.board_lvl, .pin_out, .pin_oe, .pin_in);

    // expected pin level for a control byte and the present sources
    function automatic logic exp_pin(logic [7:0] c);
        logic [2:0] sel;
        logic [3:0] v;
        hpm_tx_t t;
        sel = c[7:5];
        t = tx[c[2]];
        v = {rx.line_valid[c[3:2]], rx.frame_valid[c[3:2]], rx.pass[c[3:2]], rx.lock[c[3:2]]};
        case (c[4:2])
            3'b100: case (sel)
                3'd0: return c[1];
                3'd1: return |(rx.lock & rx_en);
                3'd2: return rx_en != 0 && (rx.lock | ~rx_en) == 4'hf;
                3'd3: return rx_en != 0 && (rx.pass | ~rx_en) == 4'hf;
                3'd5: return fs;
                default: return 1'b0;
            endcase
            3'b101: return 1'b0;
            3'b110, 3'b111: case (sel)
                3'd0: return t.rx_select != 0 && (rx.pass | ~t.rx_select) == 4'hf;
                3'd1: return |(rx.pass & t.rx_select);
                3'd2: return t.frame_active;
                3'd3: return t.line_active;
                3'd4: return t.synced;
                3'd5: return t.irq;
                default: return 1'b0;
            endcase
            default: return sel[2] ? v[sel[1:0]] : rx.remote_pins[c[3:2]][sel[1:0]];
        endcase
    endfunction

    // one comparison, counted
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // bus cycles start one negedge later, so strobes never change twice at once
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req.wr_en = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge clk);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req.rd_en = 1'b0;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, e);
    endtask

    // program a pin and look at it once the flop has taken the new source
    task automatic pin_chk(int p, logic [7:0] c);
        wr(p ? 8'h11 : 8'h10, c);
        repeat (2) @(negedge clk);
        chk({6'h00, pin_oe[p], pin_out[p]}, {6'h00, c[0], exp_pin(c)});
    endtask

    task automatic finish_test;
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // watchdog, well beyond the roughly 1600 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test;
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        req = '0;
        board_lvl = 8'h96;
        {rx, tx, fs, rx_en} = pat[0];
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk({6'h00, pin_oe}, 8'h00);
        chk(ien_o, 8'hff);
        chk({4'h0, rxen_o}, 8'h0f);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        rd(8'h0f, 8'hff);
        rd(8'h0c, 8'h0f);
        rd(8'h0e, 8'h96);
        rd(8'h20, 8'h00);
        wr(8'h0f, 8'h5a);
        wr(8'h0e, 8'h00);
        rd(8'h0e, 8'h12);
        wr(8'h0f, 8'hff);
        // every source and select code on both pins, three source patterns
        for (int k = 0; k < 3; k++) begin
            {rx, tx, fs, rx_en} = pat[k];
            wr(8'h0c, {4'h0, rx_en});
            for (int p = 0; p < 2; p++)
                for (int c = 0; c < 64; c++)
                    pin_chk(p, {c[5:0], k[0], ~c[0]});
        end
        // a driven pin reads back its own level through the board
        wr(8'h10, 8'h13);
        rd(8'h0e, 8'h97);
        // a second reset in mid-run clears the controls again
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk({6'h00, pin_oe}, 8'h00);
        rd(8'h11, 8'h00);
        rd(8'h10, 8'h00);
        finish_test;
    end
endmodule
